// File: verilog/composite_timer_freerun_pwm.sv
// composite 8/16-bit timer pairs: free-run interval, fixed and variable PWM
`timescale 1ns/1ps

module composite_timer_freerun_pwm
    import ctimer_pkg::*;
#(
    parameter int PAIRS = 2
)(
    input  wire logic               I_SYS_CLK,
    input  wire logic               I_ARST_N,
    input  wire logic               I_WB_CYC,
    input  wire logic               I_WB_STB,
    input  wire logic               I_WB_WE,
    input  wire logic [ADR_W-1:0]   I_WB_ADR,
    input  wire logic [3:0]         I_WB_SEL,
    input  wire logic [DAT_W-1:0]   I_WB_DAT,
    output logic      [DAT_W-1:0]   O_WB_DAT,
    output logic                    O_WB_ACK,
    output logic      [2*PAIRS-1:0] O_PWM_PIN,
    output logic      [2*PAIRS-1:0] O_PWM_PIN_OE
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // address decode, used for every write strobe and the read mux
    function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input int pair, input int off);
        reg_hit = (adr == ADR_W'(pair * PAIR_STRIDE + off));
    endfunction

    // count clock tick: prescaler taps of 2^sel system clocks
    function automatic logic count_tick(input logic [PRE_W-1:0] pre, input logic [2:0] sel);
        logic [PRE_W-1:0] mask;
        mask = PRE_W'((1 << sel) - 1);
        count_tick = ((pre & mask) == mask);
    endfunction

    // ****************************************************************
    // wishbone slave front end
    // ****************************************************************
    logic                   req;
    logic                   wr_hit;
    logic [REG_W-1:0]       wr_byte;
    logic [PRE_W-1:0]       pre;
    logic [REG_W-1:0]       rd_pair  [PAIRS];
    logic [2*PAIRS-1:0]     pin_lvl;
    logic [2*PAIRS-1:0]     pin_oe;

    // one request per ack; the ack cycle itself never re-triggers
    assign req     = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
    // registers live in byte lane 0 only
    assign wr_hit  = req & I_WB_WE & I_WB_SEL[0];
    assign wr_byte = I_WB_DAT[REG_W-1:0];

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_WB_ACK <= 1'b0;
        end else begin
            O_WB_ACK <= req;
        end
    end

    // read data: unmapped offsets and upper bits read zero
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_WB_DAT <= '0;
        end else if (req && !I_WB_WE) begin
            O_WB_DAT <= '0;
            for (int p = 0; p < PAIRS; p++) begin
                // only the addressed pair's mux can be non-zero, so zero words are skipped
                if (rd_pair[p] != RST_REG) begin
                    O_WB_DAT[REG_W-1:0] <= rd_pair[p];
                end
            end
        end else begin
            O_WB_DAT <= '0;
        end
    end

    // free-running prescaler shared by all count clock selections
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pre <= '0;
        end else begin
            pre <= pre + PRE_W'(1);
        end
    end

    // pins registered so every output leaves a flip-flop
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_PWM_PIN    <= '0;
            O_PWM_PIN_OE <= '0;
        end else begin
            O_PWM_PIN    <= pin_lvl;
            O_PWM_PIN_OE <= pin_oe;
        end
    end

    // ****************************************************************
    // timer pairs
    // ****************************************************************
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
        ctrl_a_t            ca   [2];
        ctrl_b_t            cb   [2];
        mode_t              md;
        logic [REG_W-1:0]   dat  [2];
        logic [REG_W-1:0]   cnt  [2];
        logic [REG_W-1:0]   shd  [2];
        logic               wr_a [2];
        logic               wr_b [2];
        logic               wr_d [2];
        logic               start[2];
        logic               tick [2];
        logic               wr_md;
        logic               cascade;
        logic               pair_var;
        fn_t                fn   [2];
        logic [WIDE_W-1:0]  cur  [2];
        logic [WIDE_W-1:0]  cmp  [2];
        logic [WIDE_W-1:0]  nxt  [2];
        logic [REG_W-1:0]   vnxt [2];

        // write strobes per register
        assign wr_a[0] = wr_hit & reg_hit(I_WB_ADR, p, OFF_CTRL_A_CH0);
        assign wr_a[1] = wr_hit & reg_hit(I_WB_ADR, p, OFF_CTRL_A_CH1);
        assign wr_b[0] = wr_hit & reg_hit(I_WB_ADR, p, OFF_CTRL_B_CH0);
        assign wr_b[1] = wr_hit & reg_hit(I_WB_ADR, p, OFF_CTRL_B_CH1);
        assign wr_d[0] = wr_hit & reg_hit(I_WB_ADR, p, OFF_DATA_CH0);
        assign wr_d[1] = wr_hit & reg_hit(I_WB_ADR, p, OFF_DATA_CH1);
        assign wr_md   = wr_hit & reg_hit(I_WB_ADR, p, OFF_MODE);

        // variable PWM is chosen by channel 0's function select
        assign pair_var = (ca[0].function_select == FN_PWM_VAR);
        // cascade never applies in variable PWM
        assign cascade  = md.cascade_select & ~pair_var;

        // per-channel view: cascade makes channel 0 a 16-bit unit
        always_comb begin
            for (int c = 0; c < 2; c++) begin
                fn[c]    = fn_t'(ca[c].function_select);
                start[c] = wr_b[c] & wr_byte[7] & ~cb[c].run_bit;
                tick[c]  = count_tick(pre, ca[c].count_clock_select);
                vnxt[c]  = cnt[c] + BYTE_ONE;
                if (cascade) begin
                    cur[c] = {cnt[1], cnt[0]};
                    cmp[c] = {shd[1], shd[0]};
                    nxt[c] = cur[c] + WIDE_ONE;
                end else begin
                    cur[c] = {8'h00, cnt[c]};
                    cmp[c] = {8'h00, shd[c]};
                    nxt[c] = {8'h00, vnxt[c]};
                end
            end
        end

        // software-only registers: clock/function selection and compare data
        always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                for (int c = 0; c < 2; c++) begin
                    ca[c]  <= ctrl_a_t'(RST_REG);
                    dat[c] <= RST_REG;
                end
            end else begin
                for (int c = 0; c < 2; c++) begin
                    if (wr_a[c]) begin
                        ca[c] <= ctrl_a_t'(wr_byte);
                    end
                    if (wr_d[c]) begin
                        dat[c] <= wr_byte;
                    end
                end
            end
        end

        // counters, compare latches, run/flag bits and toggle levels
        always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                for (int c = 0; c < 2; c++) begin
                    cb[c]  <= ctrl_b_t'(RST_REG);
                    cnt[c] <= RST_REG;
                    shd[c] <= RST_REG;
                end
                md <= mode_t'(RST_REG);
            end else begin
                // software writes; match flag clears on a written zero only
                for (int c = 0; c < 2; c++) begin
                    if (wr_b[c]) begin
                        cb[c].run_bit    <= wr_byte[7];
                        cb[c].hold       <= wr_byte[6];
                        cb[c].irq_en     <= wr_byte[5];
                        cb[c].match_flag <= cb[c].match_flag & wr_byte[2];
                        cb[c].init_level <= wr_byte[1];
                        cb[c].out_en     <= wr_byte[0];
                    end
                end
                if (wr_md) begin
                    md.input_sel      <= wr_byte[5];
                    md.cascade_select <= wr_byte[4];
                    md.edge_sel       <= wr_byte[3:0];
                end
                if (pair_var) begin
                    // variable PWM: channel 1 period, channel 0 low time
                    if (start[0] || start[1]) begin
                        cnt[0]               <= RST_REG;
                        cnt[1]               <= RST_REG;
                        shd[0]               <= dat[0];
                        shd[1]               <= dat[1];
                        md.cascade_select    <= 1'b0;
                        md.toggle_level_ch0  <= 1'b0;
                    end else if ((cb[0].run_bit || cb[1].run_bit) && tick[0]) begin
                        if (vnxt[1] == shd[1]) begin
                            // synchronous match: new period, new latches
                            cnt[0]               <= RST_REG;
                            cnt[1]               <= RST_REG;
                            shd[0]               <= dat[0];
                            shd[1]               <= dat[1];
                            cb[1].match_flag     <= 1'b1;
                            md.toggle_level_ch0  <= 1'b0;
                        end else begin
                            cnt[1] <= vnxt[1];
                            cnt[0] <= vnxt[0];
                            // low time larger than period never reaches here
                            if (vnxt[0] == shd[0]) begin
                                md.toggle_level_ch0 <= 1'b1;
                                cb[0].match_flag    <= 1'b1;
                            end
                        end
                        if (vnxt[0] == shd[0] && vnxt[1] == shd[1]) begin
                            cb[0].match_flag <= 1'b1;
                        end
                    end
                end else begin
                    for (int c = 0; c < 2; c++) begin
                        // in cascade channel 0 runs the 16-bit unit alone
                        if (!(cascade && c == 1)) begin
                            if (start[c]) begin
                                cnt[c] <= RST_REG;
                                shd[c] <= dat[c];
                                if (cascade) begin
                                    cnt[1] <= RST_REG;
                                    shd[1] <= dat[1];
                                end
                                // fixed PWM starts high; first pulse loses a count
                                if (fn[c] == FN_PWM_FIXED) begin
                                    // starting at one shortens the first pulse only; a compare of one misses it
                                    cnt[c] <= BYTE_ONE;
                                    if (c == 0 || cascade) md.toggle_level_ch0 <= 1'b1;
                                    if (c == 1 || cascade) md.toggle_level_ch1 <= 1'b1;
                                end else begin
                                    if (c == 0 || cascade) md.toggle_level_ch0 <= wr_byte[1];
                                    if (c == 1 || cascade) md.toggle_level_ch1 <= wr_byte[1];
                                end
                            end else if (cb[c].run_bit && tick[c]
                                         && (fn[c] == FN_FREE_RUN || fn[c] == FN_PWM_FIXED)) begin
                                // counter wraps naturally at the top of its range
                                if (cascade) begin
                                    cnt[0] <= nxt[c][7:0];
                                    cnt[1] <= nxt[c][15:8];
                                end else begin
                                    cnt[c] <= nxt[c][7:0];
                                end
                                if (nxt[c] == cmp[c]) begin
                                    shd[c] <= dat[c];
                                    if (cascade) shd[1] <= dat[1];
                                end
                                unique case (fn[c])
                                    FN_FREE_RUN: begin
                                        if (nxt[c] == cmp[c]) begin
                                            // keeps counting past the match
                                            cb[c].match_flag <= 1'b1;
                                            if (c == 0 || cascade) begin
                                                md.toggle_level_ch0 <= ~md.toggle_level_ch0;
                                            end
                                            if (c == 1 || cascade) begin
                                                md.toggle_level_ch1 <= ~md.toggle_level_ch1;
                                            end
                                        end
                                    end
                                    FN_PWM_FIXED: begin
                                        // flag untouched; wrap raises, match lowers
                                        if (nxt[c] == cmp[c]) begin
                                            if (c == 0 || cascade) md.toggle_level_ch0 <= 1'b0;
                                            if (c == 1 || cascade) md.toggle_level_ch1 <= 1'b0;
                                        end else if ((cascade && nxt[c] == RST_WIDE)
                                                     || (!cascade && nxt[c][7:0] == RST_REG)) begin
                                            if (c == 0 || cascade) md.toggle_level_ch0 <= 1'b1;
                                            if (c == 1 || cascade) md.toggle_level_ch1 <= 1'b1;
                                        end
                                    end
                                    default: begin
                                    end
                                endcase
                            end
                        end
                    end
                end
                // a stopped counter simply leaves the levels alone
            end
        end

        // pin levels and enables towards the shared output register
        assign pin_lvl[2*p]   = md.toggle_level_ch0;
        assign pin_lvl[2*p+1] = md.toggle_level_ch1;
        assign pin_oe[2*p]    = cb[0].out_en;
        assign pin_oe[2*p+1]  = cb[1].out_en;

        // read mux for this pair
        always_comb begin
            rd_pair[p] = RST_REG;
            if (reg_hit(I_WB_ADR, p, OFF_CTRL_A_CH0)) rd_pair[p] = ca[0];
            if (reg_hit(I_WB_ADR, p, OFF_CTRL_A_CH1)) rd_pair[p] = ca[1];
            if (reg_hit(I_WB_ADR, p, OFF_CTRL_B_CH0)) rd_pair[p] = cb[0];
            if (reg_hit(I_WB_ADR, p, OFF_CTRL_B_CH1)) rd_pair[p] = cb[1];
            if (reg_hit(I_WB_ADR, p, OFF_MODE))       rd_pair[p] = md;
            if (reg_hit(I_WB_ADR, p, OFF_DATA_CH0))   rd_pair[p] = dat[0];
            if (reg_hit(I_WB_ADR, p, OFF_DATA_CH1))   rd_pair[p] = dat[1];
        end
    end

endmodule

// File: pkg/ctimer_pkg.sv
// package: register map, field layouts and mode codes of the composite timer
package ctimer_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int ADR_W       = 6;
    localparam int DAT_W       = 32;
    localparam int REG_W       = 8;
    localparam int WIDE_W      = 16;
    localparam int PAIR_STRIDE = 32;

    // ****************************************************************
    // register offsets inside one pair (byte addresses)
    // ****************************************************************
    localparam int OFF_CTRL_A_CH0 = 'h00;
    localparam int OFF_CTRL_A_CH1 = 'h04;
    localparam int OFF_CTRL_B_CH0 = 'h08;
    localparam int OFF_CTRL_B_CH1 = 'h0c;
    localparam int OFF_MODE       = 'h10;
    localparam int OFF_DATA_CH0   = 'h14;
    localparam int OFF_DATA_CH1   = 'h18;

    // ****************************************************************
    // reset values and count increments
    // ****************************************************************
    localparam logic [7:0]  RST_REG  = 8'h00;
    localparam logic [15:0] RST_WIDE = 16'h0000;
    localparam logic [15:0] WIDE_ONE = 16'h0001;
    localparam logic [7:0]  BYTE_ONE = 8'h01;

    // ****************************************************************
    // prescaler feeding the count clock selection
    // ****************************************************************
    localparam int PRE_W = 7;

    // function selection codes
    typedef enum logic [3:0] {
        FN_ONE_SHOT  = 4'b0000,
        FN_CONTINUE  = 4'b0001,
        FN_FREE_RUN  = 4'b0010,
        FN_PWM_FIXED = 4'b0011,
        FN_PWM_VAR   = 4'b0100
    } fn_t;

    // control register a: bit7 irq enable, bits 6:4 clock, bits 3:0 function
    typedef struct packed {
        logic       ovf_irq_en;
        logic [2:0] count_clock_select;
        logic [3:0] function_select;
    } ctrl_a_t;

    // control register b
    typedef struct packed {
        logic run_bit;
        logic hold;
        logic irq_en;
        logic capture_flag;
        logic buf_full;
        logic match_flag;
        logic init_level;
        logic out_en;
    } ctrl_b_t;

    // mode register shared by both channels of a pair
    typedef struct packed {
        logic       toggle_level_ch1;
        logic       toggle_level_ch0;
        logic       input_sel;
        logic       cascade_select;
        logic [3:0] edge_sel;
    } mode_t;

endpackage

// File: sim/pwm_load.sv
// external load on the timer pins, with a pull-down on each line
`timescale 1ns/1ps

// ****************
// load model
// ****************
module pwm_load #(
    parameter int N = 4
)(
    input  wire logic [N-1:0] i_pin,
    input  wire logic [N-1:0] i_oe,
    output logic      [N-1:0] o_level
);
    // a released pin falls to the pull-down, never keeps the last level
    assign o_level = i_pin & i_oe;
endmodule

// File: sim/composite_timer_freerun_pwm_props.sv
// bus answer and pin enable checks for the composite timer
`timescale 1ns/1ps

// ****************
// checker
// ****************
module ctimer_props
    import ctimer_pkg::*;
#(
    parameter int PAIRS = 2
)(
    input wire logic               I_SYS_CLK,
    input wire logic               I_ARST_N,
    input wire logic               I_WB_CYC,
    input wire logic               I_WB_STB,
    input wire logic               I_WB_WE,
    input wire logic [ADR_W-1:0]   I_WB_ADR,
    input wire logic [3:0]         I_WB_SEL,
    input wire logic [DAT_W-1:0]   I_WB_DAT,
    input wire logic [DAT_W-1:0]   O_WB_DAT,
    input wire logic               O_WB_ACK,
    input wire logic [2*PAIRS-1:0] O_PWM_PIN,
    input wire logic [2*PAIRS-1:0] O_PWM_PIN_OE
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);

    // request taken, and the write of channel 0 control b of pair 0
    sequence s_take; I_WB_CYC && I_WB_STB && !O_WB_ACK; endsequence
    sequence s_oe_wr; s_take ##0 (I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 6'h08); endsequence

    property p_ack_next; s_take |=> O_WB_ACK; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after a request");
    property p_ack_pulse; O_WB_ACK |=> !O_WB_ACK; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_no_ack; !(I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> !O_WB_ACK; endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack without a request");
    property p_dat_idle; !O_WB_ACK |-> O_WB_DAT == '0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_dat_lane; O_WB_DAT[DAT_W-1:REG_W] == '0; endproperty
    a_dat_lane: assert property (p_dat_lane) else $error("upper read lanes not zero");
    property p_unmapped; s_take ##0 (!I_WB_WE && I_WB_ADR == 6'h1c) |=> O_WB_DAT == '0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // the enable is a registered copy, so it shows two edges after the write
    property p_oe_copy; s_oe_wr |-> ##2 O_PWM_PIN_OE[0] == $past(I_WB_DAT[0], 2); endproperty
    a_oe_copy: assert property (p_oe_copy) else $error("pin enable not the written bit");
    property p_oe_hold; $changed(O_PWM_PIN_OE) |-> $past(O_WB_ACK); endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved without a write");
endmodule

bind composite_timer_freerun_pwm ctimer_props #(.PAIRS(PAIRS)) u_props (
    .I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_PWM_PIN(O_PWM_PIN), .O_PWM_PIN_OE(O_PWM_PIN_OE));

// File: sim/composite_timer_freerun_pwm_bench.sv
// self-checking bench: register bus, free-run, fixed and variable pwm
`timescale 1ns/1ps

// ****************
// bench top
// ****************
module composite_timer_freerun_pwm_bench import ctimer_pkg::*;;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h1;
    logic [3:0]  sel_v = 4'h1;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic        ack;
    logic [3:0]  pin;
    logic [3:0]  oe;
    logic [3:0]  lvl;
    int          errors = 0;
    int          num_checks = 0;

    always #5 clk = ~clk;

    composite_timer_freerun_pwm #(.PAIRS(2)) DUT (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
        .O_WB_ACK(ack), .O_PWM_PIN(pin), .O_PWM_PIN_OE(oe));
    pwm_load #(.N(4)) u_load (.i_pin(pin), .i_oe(oe), .o_level(lvl));

    // ****************
    // shared tasks
    // ****************
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the slave's latency is not assumed, only bounded
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= sel_v;
        wdat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("MISMATCH at %0t: bus answer never came", $time);
            close_out();
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    // counts edges until the loaded pin shows v; must=0 lets the bound pass
    task automatic wt(input int i, input logic v, input int lim, input bit must, output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (lvl[i] !== v && n < lim);
        if (must && n >= lim) begin
            errors++;
            $display("MISMATCH at %0t: pin level never came", $time);
            close_out();
        end
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_regs();
        rdc(6'h08, 32'h0);
        rdc(6'h10, 32'h0);
        wr(6'h14, 8'h5a);
        sel_v = 4'h0;
        wr(6'h14, 8'ha5);         // lane 0 off: write refused
        sel_v = 4'h1;
        rdc(6'h14, 32'h5a);
        wr(6'h1c, 8'hff);
        rdc(6'h1c, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_free();
        int n;
        wr(6'h00, 8'h02);
        wr(6'h14, 8'h10);
        wr(6'h08, 8'h81);
        wt(0, 1'b1, 300, 1, n);
        chk(n, 32'h11);
        rdc(6'h08, 32'h85);
        wr(6'h14, 8'h40);          // reaches the latch only at the next match
        wt(0, 1'b0, 300, 1, n);
        wt(0, 1'b1, 300, 1, n);
        chk(n, 32'h30);
        wt(0, 1'b0, 300, 1, n);
        chk(n, 32'h100);
        wt(0, 1'b1, 300, 1, n);
        wr(6'h08, 8'h01);
        wt(0, 1'b0, 300, 0, n);
        chk(n, 32'd300);
        rdc(6'h10, 32'h40);
        $display("test free-run done");
    endtask

    task automatic t_fixed();
        int n;
        wr(6'h20, 8'h03);
        wr(6'h34, 8'h20);
        wr(6'h28, 8'h81);          // init level low, yet each period opens high
        wt(2, 1'b1, 4, 1, n);
        chk(n, 32'h1);
        wt(2, 1'b0, 300, 1, n);
        chk(n, 32'h1f);
        wt(2, 1'b1, 300, 1, n);
        chk(n, 32'he0);
        wt(2, 1'b0, 300, 1, n);
        chk(n, 32'h20);
        rdc(6'h28, 32'h81);
        wr(6'h28, 8'h00);
        $display("test fixed pwm done");
    endtask

    task automatic t_var();
        int n;
        wr(6'h10, 8'h10);
        wr(6'h00, 8'h04);
        wr(6'h04, 8'h04);
        wr(6'h14, 8'h10);
        wr(6'h18, 8'h40);
        wr(6'h08, 8'h81);
        rdc(6'h10, 32'h0);
        chk(lvl[0], 1'b0);
        wt(0, 1'b1, 300, 1, n);
        wt(0, 1'b0, 300, 1, n);
        chk(n, 32'h30);
        wr(6'h14, 8'h20);          // written during the low time
        wt(0, 1'b1, 300, 1, n);
        wt(0, 1'b0, 300, 1, n);
        chk(n, 32'h30);
        wt(0, 1'b1, 300, 1, n);
        chk(n, 32'h20);
        rdc(6'h08, 32'h85);
        rdc(6'h0c, 32'h04);
        wr(6'h14, 8'h50);
        wt(0, 1'b0, 100, 1, n);
        wt(0, 1'b1, 200, 0, n);
        chk(n, 32'd200);
        wr(6'h08, 8'h01);
        $display("test variable pwm done");
    endtask

    // second pair cascaded: 16-bit compare, both pins toggle together
    task automatic t_casc();
        int n;
        wr(6'h30, 8'h10);
        wr(6'h20, 8'h02);
        wr(6'h34, 8'h20);
        wr(6'h38, 8'h01);
        wr(6'h2c, 8'h01);
        wr(6'h28, 8'h81);
        wt(2, 1'b1, 300, 1, n);
        chk(n, 32'h121);
        chk(lvl[3], 1'b1);
        wr(6'h28, 8'h00);
        $display("test cascade free-run done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_free();
        t_fixed();
        t_casc();
        t_var();
        close_out();
    end
endmodule
